/* File: rtl/cdrld_freq_cmp.sv */
// Windowed frequency comparator between two tick streams
`timescale 1ns/1ps
module cdrld_freq_cmp (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rstn_in,
  // Tick streams
  input  wire logic restart_in,
  input  wire logic target_tick_in,
  input  wire logic osc_tick_in,
  // Results
  output logic      done_out,
  output logic      within_lock_out,
  output logic      beyond_unlock_out
);

  logic [16:0] win_reg;
  logic [16:0] win_next;
  logic [16:0] osc_reg;
  logic [16:0] osc_next;
  logic        done_reg;
  logic        in_reg;
  logic        out_reg;

  wire         win_end  = target_tick_in && (win_reg == cdrld_pkg::CDRLD_WIN_CNT - 17'h1);
  wire         osc_sat  = (osc_reg == 17'h1FFFF);
  wire  [16:0] osc_last = osc_reg + {16'h0000, osc_tick_in && !osc_sat};
  wire  [16:0] err      = (osc_last >= cdrld_pkg::CDRLD_WIN_CNT) ?
                          osc_last - cdrld_pkg::CDRLD_WIN_CNT :
                          cdrld_pkg::CDRLD_WIN_CNT - osc_last;

  assign win_next = (restart_in || win_end) ? 17'h0 :
                    win_reg + {16'h0000, target_tick_in};
  assign osc_next = (restart_in || win_end) ? 17'h0 : osc_last;

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      win_reg  <= 17'h0;
      osc_reg  <= 17'h0;
      done_reg <= 1'b0;
      in_reg   <= 1'b0;
      out_reg  <= 1'b0;
    end else begin
      win_reg  <= win_next;
      osc_reg  <= osc_next;
      done_reg <= win_end && !restart_in;
      if (win_end && !restart_in) begin
        in_reg  <= (err <= cdrld_pkg::CDRLD_LOCK_ERR);
        out_reg <= (err >  cdrld_pkg::CDRLD_UNLOCK_ERR);
      end
    end
  end

  assign done_out          = done_reg;
  assign within_lock_out   = in_reg;
  assign beyond_unlock_out = out_reg;

endmodule

/* File: rtl/cdrld_pkg.sv */
// Constants for the recovery loop configuration and lock detector
//
// Functional notes
// RULE_01: Phase offset applied only at 5.65 Gbps up.
// RULE_02: Phase offset signed, 1/32 UI steps, +-0.25 UI.
// RULE_03: Bandwidth field three bits, resets to four.
// RULE_04: Bandwidth scales linearly as field over four.
// RULE_05: Host never writes zero bandwidth field.
// RULE_06: Adaptive equalizer only above 5.5 Gbps.
// RULE_07: Manual equalizer strength or adaptive eye loop.
// RULE_08: Termination floats when bit seven is one.
// RULE_09: Normal, reference-aided and sticky lock modes.
// RULE_10: Lock within 250 ppm, then enable phase loop.
// RULE_11: Above 1000 ppm relock; stay until 250 ppm.
// RULE_12: Recovery mode value two selects reference aid.
// RULE_13: Host writes reference range and divide ratio.
// RULE_14: Host clears reference buffer power-down bit.
// RULE_15: Host should keep fast acquisition bit set.
// RULE_16: Reference mode compares divided oscillator, reference.
// RULE_17: Sticky flag cleared by writing one then zero.
// RULE_18: Loss of lock is a registered glitch-free level.
package cdrld_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] CDRLD_MODE_ADDR   = 8'h08;
  localparam logic [7:0] CDRLD_REFDIV_ADDR = 8'h0F;
  localparam logic [7:0] CDRLD_BW_ADDR     = 8'h10;
  localparam logic [7:0] CDRLD_PHASE_ADDR  = 8'h14;
  localparam logic [7:0] CDRLD_EQ_ADDR     = 8'h16;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CDRLD_PHASE_LSB  = 0;
  localparam int CDRLD_BW_LSB     = 0;
  localparam int CDRLD_MODE_LSB   = 4;
  localparam int CDRLD_STCLR_BIT  = 2;
  localparam int CDRLD_RATIO_LSB  = 0;
  localparam int CDRLD_RANGE_LSB  = 4;
  localparam int CDRLD_EQSTR_LSB  = 0;
  localparam int CDRLD_TERM_BIT   = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and encodings
  localparam logic [2:0] CDRLD_BW_RESET    = 3'h4;
  localparam logic [2:0] CDRLD_BW_UNITY    = 3'h4;
  localparam logic [2:0] CDRLD_MODE_RESET  = 3'h0;
  localparam logic [2:0] CDRLD_MODE_REFAID = 3'h2;
  localparam logic [3:0] CDRLD_PHASE_RESET = 4'h0;
  localparam logic [7:0] CDRLD_EQ_RESET    = 8'h00;
  localparam logic [5:0] CDRLD_REFDIV_RESET = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Rate thresholds in Mbps
  localparam logic [13:0] CDRLD_PHASE_MIN_MBPS = 14'h1612;
  localparam logic [13:0] CDRLD_EQ_MIN_MBPS    = 14'h157C;

  ////////////////////////////////////////////////////////////////////////////
  // Frequency comparison window and ppm thresholds
  localparam int CDRLD_WIN_TICKS  = 40000;
  localparam int CDRLD_LOCK_PPM   = 250;
  localparam int CDRLD_UNLOCK_PPM = 1000;
  localparam logic [16:0] CDRLD_WIN_CNT = 17'(CDRLD_WIN_TICKS);
  localparam logic [16:0] CDRLD_LOCK_ERR =
    17'(CDRLD_WIN_TICKS * CDRLD_LOCK_PPM / 1000000);
  localparam logic [16:0] CDRLD_UNLOCK_ERR =
    17'(CDRLD_WIN_TICKS * CDRLD_UNLOCK_PPM / 1000000);

  ////////////////////////////////////////////////////////////////////////////
  // Lock state machine
  typedef enum logic [1:0] {
    CDRLD_ST_ACQ  = 2'b01,
    CDRLD_ST_LOCK = 2'b10
  } cdrld_state_t;

endpackage

/* File: rtl/cdrld_top.sv */
// Recovery loop configuration, equalizer control and lock detector
`timescale 1ns/1ps
module cdrld_top (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  // Register image loads, shared data byte
  input  wire logic [7:0]  cfg_data_in,
  input  wire logic        mode_load_in,
  input  wire logic        refdiv_load_in,
  input  wire logic        bw_load_in,
  input  wire logic        phase_load_in,
  input  wire logic        eq_load_in,
  // Other configuration levels
  input  wire logic        lol_static_mode_in,
  input  wire logic        adaptive_eq_in,
  // Measured data rate in Mbps
  input  wire logic [13:0] rate_mbps_in,
  // Frequency ticks from same-clock dividers
  input  wire logic        osc_tick_in,
  input  wire logic        data_tick_in,
  input  wire logic        ref_tick_in,
  // Eye quality from the phase detector
  input  wire logic        eye_valid_in,
  input  wire logic [7:0]  eye_metric_in,
  // Loop configuration outputs
  output logic [3:0]       sample_phase_out,
  output logic [2:0]       loop_bandwidth_scale_out,
  output logic [4:0]       bw_gain_q2_out,
  output logic [3:0]       equalizer_setting_out,
  output logic             term_float_out,
  output logic [1:0]       reference_range_out,
  output logic [3:0]       data_reference_divide_out,
  output logic             reference_aided_mode_out,
  // Lock detector outputs
  output logic             loss_of_lock_out,
  output logic             sticky_lol_out,
  output logic             freq_loop_enable_out,
  output logic             digital_phase_loop_enable_out,
  output logic             acq_restart_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register images

  logic [2:0] mode_reg;
  logic       stclr_reg;
  logic [5:0] refdiv_reg;
  logic [2:0] bw_reg;
  logic [3:0] phase_reg;
  logic [7:0] eq_reg;

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      mode_reg   <= cdrld_pkg::CDRLD_MODE_RESET;
      stclr_reg  <= 1'b0;
      refdiv_reg <= cdrld_pkg::CDRLD_REFDIV_RESET;
      bw_reg     <= cdrld_pkg::CDRLD_BW_RESET; // RULE_03
      phase_reg  <= cdrld_pkg::CDRLD_PHASE_RESET;
      eq_reg     <= cdrld_pkg::CDRLD_EQ_RESET;
    end else begin
      if (mode_load_in) begin
        mode_reg  <= cfg_data_in[cdrld_pkg::CDRLD_MODE_LSB +: 3];
        stclr_reg <= cfg_data_in[cdrld_pkg::CDRLD_STCLR_BIT];
      end
      if (refdiv_load_in)
        refdiv_reg <= cfg_data_in[5:0];
      if (bw_load_in)
        bw_reg <= cfg_data_in[cdrld_pkg::CDRLD_BW_LSB +: 3]; // RULE_03
      if (phase_load_in)
        phase_reg <= cfg_data_in[cdrld_pkg::CDRLD_PHASE_LSB +: 4];
      if (eq_load_in)
        eq_reg <= cfg_data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate qualification and decode

  wire       phase_rate_ok = rate_mbps_in >= cdrld_pkg::CDRLD_PHASE_MIN_MBPS;
  wire       eq_rate_ok    = rate_mbps_in >  cdrld_pkg::CDRLD_EQ_MIN_MBPS;
  wire       ref_mode      = mode_reg == cdrld_pkg::CDRLD_MODE_REFAID; // RULE_12
  wire [3:0] ratio         = refdiv_reg[cdrld_pkg::CDRLD_RATIO_LSB +: 4];
  wire [1:0] range         = refdiv_reg[cdrld_pkg::CDRLD_RANGE_LSB +: 2];
  wire       adapt_on      = adaptive_eq_in && eq_rate_ok; // RULE_06
  wire [3:0] manual_eq     = eq_reg[cdrld_pkg::CDRLD_EQSTR_LSB +: 4]; // RULE_07

  ////////////////////////////////////////////////////////////////////////////
  // Applied configuration, registered

  logic [3:0] phase_app_reg;
  logic [4:0] gain_reg;
  logic       term_reg;

  // Signed offset, 1/32 UI steps, -8..+7 stays within 0.25 UI
  wire  [3:0] phase_next = phase_rate_ok ? phase_reg : 4'h0; // RULE_01 RULE_02
  // Gain in quarters: field/4 as a Q2 value
  wire  [4:0] gain_next  = {2'b00, bw_reg}; // RULE_04

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      phase_app_reg <= 4'h0;
      gain_reg      <= {2'b00, cdrld_pkg::CDRLD_BW_UNITY};
      term_reg      <= 1'b0;
    end else begin
      phase_app_reg <= phase_next; // RULE_01
      gain_reg      <= gain_next; // RULE_04
      term_reg      <= eq_reg[cdrld_pkg::CDRLD_TERM_BIT]; // RULE_08
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Adaptive equalizer sweep: try every strength, keep the best eye

  logic [3:0] try_reg;
  logic [3:0] best_reg;
  logic [7:0] best_metric_reg;
  logic [3:0] applied_eq_reg;
  logic [3:0] eq_out_reg;
  logic       sweep_done_reg;

  wire sweep_last = try_reg == 4'hF;
  wire better     = eye_metric_in > best_metric_reg;
  wire [3:0] win_set = better ? try_reg : best_reg;
  wire sweeping   = adapt_on && !sweep_done_reg;
  // Trial strength while sweeping, then the winner; manual when off
  wire [3:0] eq_pick = !adapt_on      ? manual_eq :
                       sweep_done_reg ? applied_eq_reg : try_reg;

  // One sweep per enable; dropping the enable rearms it
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      try_reg         <= 4'h0;
      best_reg        <= 4'h0;
      best_metric_reg <= 8'h00;
      applied_eq_reg  <= 4'h0;
      eq_out_reg      <= 4'h0;
      sweep_done_reg  <= 1'b0;
    end else begin
      if (!adapt_on) begin
        try_reg         <= 4'h0;
        best_reg        <= 4'h0;
        best_metric_reg <= 8'h00;
        applied_eq_reg  <= manual_eq;
        sweep_done_reg  <= 1'b0;
      end else if (sweeping && eye_valid_in) begin // RULE_07
        try_reg <= try_reg + 4'h1;
        if (sweep_last) begin
          applied_eq_reg <= win_set;
          sweep_done_reg <= 1'b1;
        end else if (better) begin
          best_reg        <= try_reg;
          best_metric_reg <= eye_metric_in;
        end
      end
      eq_out_reg <= eq_pick; // RULE_06 RULE_07
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference-aided oscillator divider

  logic [3:0] odiv_reg;
  wire        odiv_wrap = odiv_reg >= ratio;
  wire        odiv_tick = osc_tick_in && odiv_wrap;

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in)
      odiv_reg <= 4'h0;
    else if (osc_tick_in)
      odiv_reg <= odiv_wrap ? 4'h0 : odiv_reg + 4'h1;
  end

  // Divided oscillator against raw reference, or raw against data
  wire cmp_target = ref_mode ? ref_tick_in : data_tick_in; // RULE_16
  wire cmp_osc    = ref_mode ? odiv_tick : osc_tick_in; // RULE_16

  ////////////////////////////////////////////////////////////////////////////
  // Frequency comparison

  logic ref_mode_reg;
  logic cmp_done;
  logic cmp_in;
  logic cmp_out;

  // Changing the detector mode discards the partial window
  wire  mode_change = ref_mode != ref_mode_reg;

  cdrld_freq_cmp u_cmp (
    .sys_clk_in        (sys_clk_in),
    .rstn_in           (rstn_in),
    .restart_in        (mode_change),
    .target_tick_in    (cmp_target),
    .osc_tick_in       (cmp_osc),
    .done_out          (cmp_done),
    .within_lock_out   (cmp_in),
    .beyond_unlock_out (cmp_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Lock state machine

  cdrld_pkg::cdrld_state_t state_reg;
  cdrld_pkg::cdrld_state_t state_next;
  logic                    restart_reg;

  wire go_lock   = cmp_done && cmp_in; // RULE_10
  wire go_unlock = cmp_done && cmp_out; // RULE_11

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      cdrld_pkg::CDRLD_ST_ACQ:
        if (go_lock)
          state_next = cdrld_pkg::CDRLD_ST_LOCK; // RULE_10 RULE_16
      cdrld_pkg::CDRLD_ST_LOCK:
        if (go_unlock || mode_change)
          state_next = cdrld_pkg::CDRLD_ST_ACQ; // RULE_11 RULE_16
      default:
        state_next = cdrld_pkg::CDRLD_ST_ACQ;
    endcase
  end

  wire entering_acq = (state_reg == cdrld_pkg::CDRLD_ST_LOCK) &&
                      (state_next == cdrld_pkg::CDRLD_ST_ACQ);

  ////////////////////////////////////////////////////////////////////////////
  // Sticky loss of lock: clear on a one then zero of the clear bit

  logic sticky_reg;
  logic clr_armed_reg;
  logic lol_reg;

  wire clr_fall  = clr_armed_reg && !stclr_reg; // RULE_17
  wire lol_event = entering_acq;

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state_reg     <= cdrld_pkg::CDRLD_ST_ACQ;
      restart_reg   <= 1'b0;
      ref_mode_reg  <= 1'b0;
      sticky_reg    <= 1'b0;
      clr_armed_reg <= 1'b0;
      lol_reg       <= 1'b1;
    end else begin
      state_reg     <= state_next;
      restart_reg   <= entering_acq; // RULE_11
      ref_mode_reg  <= ref_mode;
      clr_armed_reg <= stclr_reg;
      // A new loss wins over a clear in the same cycle
      if (lol_event)
        sticky_reg <= 1'b1; // RULE_09
      else if (clr_fall)
        sticky_reg <= 1'b0; // RULE_17
      lol_reg <= lol_static_mode_in ?
                 (sticky_reg || lol_event) :
                 (state_next == cdrld_pkg::CDRLD_ST_ACQ); // RULE_18 RULE_09
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sample_phase_out              = phase_app_reg;
  assign loop_bandwidth_scale_out      = bw_reg;
  assign bw_gain_q2_out                = gain_reg;
  assign equalizer_setting_out         = eq_out_reg;
  assign term_float_out                = term_reg;
  assign reference_range_out           = range;
  assign data_reference_divide_out     = ratio;
  assign reference_aided_mode_out      = ref_mode_reg;
  assign loss_of_lock_out              = lol_reg;
  assign sticky_lol_out                = sticky_reg;
  assign freq_loop_enable_out          =
    state_reg == cdrld_pkg::CDRLD_ST_ACQ;
  assign digital_phase_loop_enable_out =
    state_reg == cdrld_pkg::CDRLD_ST_LOCK; // RULE_10
  assign acq_restart_out               = restart_reg;

endmodule

/* File: verif/cdr_lock_detect_loop_config_tb.sv */
// Self-checking bench for the loop configuration and lock detector
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module cdr_lock_detect_loop_config_tb;
  logic        sys_clk_in;
  logic        rstn_in;
  logic [7:0]  cfg;
  logic [4:0]  ld;
  logic        lstat;
  logic [13:0] rate;
  logic [7:0]  skip;
  logic        dtk, rtk, otk;
  logic [3:0]  ph, eq, dv;
  logic [2:0]  bw;
  logic [4:0]  gn;
  logic [1:0]  rg;
  logic        tf, ra, loss_of_lock, stk, fll, dpl, rst;
  logic        adapt, eyev;
  logic [7:0]  eyem;
  logic [7:0]  refclk_ctl;
  logic [31:0] seed = 32'h7CAB;
  int          miscompares = 0;
  int          n_checks = 0;
  int          n_rst = 0;

  cdrld_tick_src cdrld_tick_src_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .skip_in(skip), .reference_buffer_powerdown_in(refclk_ctl[2]),
    .data_tick_out(dtk), .ref_tick_out(rtk),
    .osc_tick_out(otk));
  cdrld_top cdrld_top_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .cfg_data_in(cfg), .mode_load_in(ld[0]), .refdiv_load_in(ld[1]),
    .bw_load_in(ld[2]), .phase_load_in(ld[3]), .eq_load_in(ld[4]),
    .lol_static_mode_in(lstat), .adaptive_eq_in(adapt), .rate_mbps_in(rate),
    .osc_tick_in(otk), .data_tick_in(dtk), .ref_tick_in(rtk),
    .eye_valid_in(eyev), .eye_metric_in(eyem), .sample_phase_out(ph),
    .loop_bandwidth_scale_out(bw), .bw_gain_q2_out(gn),
    .equalizer_setting_out(eq), .term_float_out(tf),
    .reference_range_out(rg), .data_reference_divide_out(dv),
    .reference_aided_mode_out(ra), .loss_of_lock_out(loss_of_lock),
    .sticky_lol_out(stk), .freq_loop_enable_out(fll),
    .digital_phase_loop_enable_out(dpl), .acq_restart_out(rst));

  always #5 sys_clk_in = ~sys_clk_in;
  always @(negedge sys_clk_in) if (rst === 1'b1) n_rst++;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic ld_byte(input int k, input logic [7:0] d);
    @(posedge sys_clk_in) #1;
    cfg = d;
    ld[k] = 1'b1;
    @(posedge sys_clk_in) #1;
    ld = 5'h00;
  endtask

  task automatic settle();
    repeat (3) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic wait_lol(input logic v);
    for (int k = 0; k < 45000 && loss_of_lock !== v; k++) @(posedge sys_clk_in);
    #1;
    `CHK("lol", v, loss_of_lock)
  endtask

  task automatic complete_run();
    if (miscompares == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #1_000_000;
    miscompares++;
    complete_run();
  end

  initial begin
    logic [7:0]  d;
    logic [7:0]  m;
    logic [7:0]  bm;
    int          r;
    int          bi;
    sys_clk_in = 0; rstn_in = 0; cfg = 0; ld = 0;
    lstat = 0; rate = 0; skip = 0;
    adapt = 0; eyev = 0; eyem = 0; refclk_ctl = 8'h04;
    repeat (2) @(posedge sys_clk_in);
    #1 rstn_in = 1;
    #1;
    `CHK("lol rst", 1'b1, loss_of_lock)
    `CHK("bw rst", 3'h4, bw)
    `CHK("gain rst", 5'h04, gn)
    ////////////////////////////////////////////////////////////////////////
    // Bandwidth field, never zero
    for (int v = 1; v < 8; v++) begin
      ld_byte(2, 8'(v));
      settle();
      `CHK("bw", 3'(v), bw)
      `CHK("gain", 5'(v), gn)
    end
    ////////////////////////////////////////////////////////////////////////
    // Phase offset gated by rate, boundary first
    for (int i = 0; i < 8; i++) begin
      r = (i == 0) ? 5649 : (i == 1) ? 5650 : 5000 + int'(xs() % 1300);
      d = 8'(xs());
      rate = 14'(r);
      ld_byte(3, d);
      settle();
      `CHK("phase", (r >= 5650) ? d[3:0] : 4'h0, ph)
    end
    ////////////////////////////////////////////////////////////////////////
    // Equalizer byte, termination, reference fields
    for (int i = 0; i < 4; i++) begin
      d = 8'(xs());
      ld_byte(4, d);
      ld_byte(1, ~d);
      settle();
      `CHK("term", d[7], tf)
      `CHK("eq", d[3:0], eq)
      `CHK("range", ~d[5:4], rg)
      `CHK("divide", ~d[3:0], dv)
    end
    ////////////////////////////////////////////////////////////////////////
    // Adaptive sweep above 5.5 Gbps keeps the best eye, manual at 5.5
    rate = 14'h1770;
    adapt = 1'b1;
    bi = 0;
    bm = 8'h00;
    for (int t = 0; t < 16; t++) begin
      m = 8'(xs());
      if (m > bm) begin
        bi = t;
        bm = m;
      end
      @(posedge sys_clk_in) #1;
      eyev = 1'b1;
      eyem = m;
    end
    @(posedge sys_clk_in) #1;
    eyev = 1'b0;
    settle();
    `CHK("eq adapt", 4'(bi), eq)
    rate = 14'h157C;
    settle();
    `CHK("eq manual", d[3:0], eq)
    adapt = 1'b0;
    refclk_ctl = 8'h01;
    ld_byte(0, 8'h20);
    settle();
    `CHK("ref aid", 1'b1, ra)
    ld_byte(0, 8'h00);
    settle();
    `CHK("ref aid", 1'b0, ra)
    ////////////////////////////////////////////////////////////////////////
    // Lock on matched ticks, unlock on 1 percent offset
    wait_lol(1'b0);
    `CHK("digital_phase_loop", 1'b1, dpl)
    `CHK("fll", 1'b0, fll)
    skip = 8'h64;
    wait_lol(1'b1);
    `CHK("restart", 1, n_rst)
    `CHK("fll", 1'b1, fll)
    `CHK("sticky", 1'b1, stk)
    ////////////////////////////////////////////////////////////////////////
    // Static mode mirrors sticky, cleared by one then zero
    lstat = 1'b1;
    ld_byte(0, 8'h04);
    ld_byte(0, 8'h00);
    settle();
    `CHK("sticky clr", 1'b0, stk)
    `CHK("lol static", 1'b0, loss_of_lock)
    complete_run();
  end
endmodule

/* File: verif/cdrld_props.sv */
// Concurrent checks on the lock detector and configuration ports
`timescale 1ns/1ps
module cdrld_props (
  // Clock, reset and loads
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  input wire logic [7:0]  cfg_data_in,
  input wire logic        mode_load_in,
  input wire logic        refdiv_load_in,
  input wire logic        bw_load_in,
  input wire logic        eq_load_in,
  input wire logic        lol_static_mode_in,
  input wire logic [13:0] rate_mbps_in,
  // Observed outputs
  input wire logic [3:0]  sample_phase_out,
  input wire logic [2:0]  loop_bandwidth_scale_out,
  input wire logic [4:0]  bw_gain_q2_out,
  input wire logic        term_float_out,
  input wire logic [1:0]  reference_range_out,
  input wire logic [3:0]  data_reference_divide_out,
  input wire logic        reference_aided_mode_out,
  input wire logic        loss_of_lock_out,
  input wire logic        sticky_lol_out,
  input wire logic        freq_loop_enable_out,
  input wire logic        digital_phase_loop_enable_out,
  input wire logic        acq_restart_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  a_bw_field_load: assert property (bw_load_in |=>
    loop_bandwidth_scale_out == $past(cfg_data_in[2:0])) else $error("bw field");
  a_bw_gain_q2: assert property (bw_load_in |=> ##1
    bw_gain_q2_out == {2'b00, $past(cfg_data_in[2:0], 2)}) else $error("gain");
  a_phase_low_rate: assert property (
    $past(rate_mbps_in) < cdrld_pkg::CDRLD_PHASE_MIN_MBPS &&
    $past(rate_mbps_in, 2) < cdrld_pkg::CDRLD_PHASE_MIN_MBPS
    |-> sample_phase_out == 4'h0) else $error("phase at low rate");
  a_term_float_load: assert property (eq_load_in |=> ##1
    term_float_out == $past(cfg_data_in[7], 2)) else $error("term float");
  a_refdiv_load: assert property (refdiv_load_in |=>
    reference_range_out == $past(cfg_data_in[5:4]) &&
    data_reference_divide_out == $past(cfg_data_in[3:0])) else $error("refdiv");
  a_refaid_select: assert property (mode_load_in |=> ##1
    reference_aided_mode_out == ($past(cfg_data_in[6:4], 2) == 3'h2))
    else $error("ref aid mode");
  a_loop_exclusive: assert property (
    digital_phase_loop_enable_out != freq_loop_enable_out) else $error("loops");
  a_lol_normal_mode: assert property (
    !lol_static_mode_in && !$past(lol_static_mode_in)
    |-> loss_of_lock_out == freq_loop_enable_out) else $error("lol normal");
  a_restart_single: assert property (acq_restart_out |=>
    !acq_restart_out && !digital_phase_loop_enable_out) else $error("restart");
  a_sticky_clear: assert property ($fell(sticky_lol_out) |->
    $past(mode_load_in) || $past(mode_load_in, 2) || $past(mode_load_in, 3))
    else $error("sticky clear");
endmodule

bind cdrld_top cdrld_props cdrld_props_i (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .cfg_data_in(cfg_data_in),
  .mode_load_in(mode_load_in), .refdiv_load_in(refdiv_load_in),
  .bw_load_in(bw_load_in), .eq_load_in(eq_load_in),
  .lol_static_mode_in(lol_static_mode_in), .rate_mbps_in(rate_mbps_in),
  .sample_phase_out(sample_phase_out),
  .loop_bandwidth_scale_out(loop_bandwidth_scale_out),
  .bw_gain_q2_out(bw_gain_q2_out), .term_float_out(term_float_out),
  .reference_range_out(reference_range_out),
  .data_reference_divide_out(data_reference_divide_out),
  .reference_aided_mode_out(reference_aided_mode_out),
  .loss_of_lock_out(loss_of_lock_out), .sticky_lol_out(sticky_lol_out),
  .freq_loop_enable_out(freq_loop_enable_out),
  .digital_phase_loop_enable_out(digital_phase_loop_enable_out),
  .acq_restart_out(acq_restart_out));

/* File: verif/cdrld_tick_src.sv */
// Tick source standing in for the incoming stream and the oscillator
`timescale 1ns/1ps
module cdrld_tick_src (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rstn_in,
  // Oscillator drops one tick in every skip_in ticks, 0 = none
  input  wire logic [7:0] skip_in,
  // Host reference buffer power-down, 1 = no reference ticks
  input  wire logic       reference_buffer_powerdown_in,
  // Tick streams
  output logic            data_tick_out,
  output logic            ref_tick_out,
  output logic            osc_tick_out
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;

  assign cnt_next = (cnt_reg + 8'h01 >= skip_in) ? 8'h00 : cnt_reg + 8'h01;

  always_ff @(posedge sys_clk_in) begin
    cnt_reg <= rstn_in ? cnt_next : 8'h00;
  end

  assign data_tick_out = rstn_in;
  assign ref_tick_out  = rstn_in && !reference_buffer_powerdown_in;
  // Frequency offset of 1/skip between oscillator and stream
  assign osc_tick_out  = rstn_in && !(skip_in != 8'h00 && cnt_reg == 8'h00);
endmodule
